// ---- core/ats_pkg.sv ----
// Purpose: shared constants and types for the analyzer trigger self-test
// Assumes: one 20 MHz clock, module ROM mapped at 16-bit offsets
// Notes:   every number used by both ends lives here
package ats_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_NS      = 50;
  localparam int unsigned MS_NS       = 1_000_000;
  localparam int unsigned MS_CYC      = MS_NS / CLK_NS;
  localparam int unsigned KEY_WIN_MS  = 3000;
  localparam int unsigned KEY_WIN_CYC = KEY_WIN_MS * MS_CYC;
  localparam int unsigned SLOW_NS     = 10_000;
  localparam int unsigned SLOW_CYC    = SLOW_NS / CLK_NS;
  localparam logic [7:0]  SEQ_WAIT_MS = 8'h02;
  // ----------------------------------------------------------------
  // module ROM layout
  // ----------------------------------------------------------------
  localparam logic [15:0] ROM_BASE    = 16'hE000;
  localparam logic [15:0] ROM_LEN     = 16'hE010;
  localparam logic [15:0] ROM_WAIT    = 16'hE011;
  localparam logic [15:0] ROM_ACQ_SUM = 16'hE012;
  localparam logic [15:0] ROM_REC     = 16'hE014;
  localparam logic [7:0]  TRL_LO      = 8'hFC;
  localparam logic [7:0]  TRL_HI      = 8'hFD;
  localparam logic [7:0]  SUM_LO      = 8'hFE;
  localparam logic [7:0]  SUM_HI      = 8'hFF;
  // ----------------------------------------------------------------
  // acquisition setup and failure codes
  // ----------------------------------------------------------------
  localparam logic [9:0]  ACQ_LAST    = 10'h3FF;
  localparam logic [7:0]  SEQ_DELAY   = 8'hF0;
  localparam logic [7:0]  SEQ_PRESET  = 8'hFD;
  localparam logic [3:0]  FC_TRL_HI   = 4'h3;
  localparam logic [19:0] FC_SLOW     = 20'h0_FF60;
  localparam logic [3:0]  FB_SLOW     = 4'h1;
  localparam logic [19:0] FC_TRIG     = 20'h2_E803;
  localparam logic [3:0]  FB_TRIG     = 4'h7;
  localparam logic [19:0] FC_ACQ_SUM  = 20'h3_E035;
  // ----------------------------------------------------------------
  // apb register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  A_CTRL      = 8'h00;
  localparam logic [7:0]  A_STAT      = 8'h04;
  localparam logic [7:0]  A_CNT       = 8'h08;
  localparam int unsigned CTRL_START  = 0;
  localparam int unsigned CTRL_TEST   = 4;
  localparam int unsigned CTRL_EXP    = 8;
  localparam logic [2:0]  TEST_ROM    = 3'h1;
  localparam logic [2:0]  TEST_SINGLE = 3'h3;
  localparam logic [2:0]  TEST_SEQ    = 3'h4;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  typedef logic [39:0] ats_word_t;
endpackage

// ---- core/ats_if.sv ----
// Purpose: link between the self-test sequencer and the analyzer logic
// Assumes: both ends on pclk
// Notes:   command strobes are one-cycle pulses
`timescale 1ns/1ps
interface ats_if;
  ats_pkg::ats_word_t [3:0] rec_val;
  ats_pkg::ats_word_t [3:0] rec_care;
  logic                     ext_care;
  logic [9:0]               qual_care;
  logic                     shift_div;
  logic                     sm_seq;
  logic [7:0]               delay;
  logic [7:0]               preset;
  logic                     cmd_display;
  logic                     cmd_store;
  logic [9:0]               mem_raddr;
  logic                     slow_clk;
  logic                     store_mode;
  logic [7:0]               mem_rdata;
  logic [15:0]              cnt1;
  logic [15:0]              cnt2;
  modport seq (output rec_val, rec_care, ext_care, qual_care, shift_div, sm_seq, delay,
               preset, cmd_display, cmd_store, mem_raddr,
               input slow_clk, store_mode, mem_rdata, cnt1, cnt2);
  modport anl (input rec_val, rec_care, ext_care, qual_care, shift_div, sm_seq, delay,
               preset, cmd_display, cmd_store, mem_raddr,
               output slow_clk, store_mode, mem_rdata, cnt1, cnt2);
endinterface

// ---- core/ats_anl.sv ----
// Purpose: analyzer side: recognizers, trigger state machine, counters, memory
// Assumes: sample_valid marks one stimulus clock, synchronous to pclk
// Notes:   memory holds 256 samples of 32 bits (1024 bytes)
`timescale 1ns/1ps
module ats_anl #(
  parameter int unsigned KEY_WIN_CYC = ats_pkg::KEY_WIN_CYC
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // sequencer link
  ats_if.anl               bus,
  // stimulus and panel
  input  wire logic        sample_valid,
  input  wire logic [23:0] sample_addr,
  input  wire logic [15:0] sample_data,
  input  wire logic [9:0]  sample_qual,
  input  wire logic        ext_trig,
  input  wire logic        key_held,
  output logic             diag_req,
  output logic             trig_main,
  output logic             trig_timing
);
  typedef enum logic [1:0] {ST_ONE, ST_TWO, ST_THREE, ST_FOUR} ats_st_t;

  ats_st_t     st_q;
  logic        store_q, trig_q, take_q, diag_q, hitp_q;
  logic [7:0]  dly_q, wptr_q, rd_q;
  logic [15:0] cnt1_q, cnt2_q;
  logic [11:0] gap_q;
  logic [31:0] win_q;
  logic [31:0] mem [256];
  logic [31:0] rword;
  logic [3:0]  m;
  ats_pkg::ats_word_t smp;

  // ----------------------------------------------------------------
  // recognizers and sample qualification
  // ----------------------------------------------------------------
  assign smp = {sample_addr, sample_data};
  for (genvar gi = 0; gi < 4; gi++) begin : g_rec
    assign m[gi] = (((smp ^ bus.rec_val[gi]) & bus.rec_care[gi]) == '0) &&
                   (!bus.ext_care || ext_trig);
  end
  wire qual_ok = ((~sample_qual & bus.qual_care) == '0);
  wire take    = sample_valid && qual_ok && (!bus.shift_div || take_q);
  wire act     = take && store_q;
  wire hit_one = (st_q == ST_ONE) && m[0];
  wire hit     = act && !trig_q && (bus.sm_seq ? (st_q == ST_FOUR) && m[3] : hit_one);
  // the trigger sample is qualified out of memory in the sequence program
  wire supp    = hit && bus.sm_seq;

  // ----------------------------------------------------------------
  // trigger state machine, counters, acquisition control
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q    <= ST_ONE;
      store_q <= 1'b0;
      trig_q  <= 1'b0;
      take_q  <= 1'b1;
      dly_q   <= 8'h00;
      wptr_q  <= 8'h00;
      cnt1_q  <= 16'h0000;
      cnt2_q  <= 16'h0000;
      hitp_q  <= 1'b0;
    end else begin
      hitp_q <= hit;
      if (sample_valid && qual_ok) begin
        take_q <= !take_q;
      end
      if (bus.cmd_store) begin
        store_q <= 1'b1;
        trig_q  <= 1'b0;
        wptr_q  <= bus.preset;
        st_q    <= ST_ONE;
      end else if (bus.cmd_display) begin
        store_q <= 1'b0;
      end else if (act) begin
        if (!supp) begin
          wptr_q <= wptr_q + 8'h01;
        end
        if (hit) begin
          trig_q <= 1'b1;
          dly_q  <= bus.delay;
          if (bus.delay == 8'h00) begin
            store_q <= 1'b0;
          end
        end else if (trig_q) begin
          dly_q <= dly_q - 8'h01;
          if (dly_q == 8'h01) begin
            store_q <= 1'b0;
          end
        end
        if (bus.sm_seq && !trig_q) begin
          unique case (st_q)
            ST_ONE:   if (m[0]) st_q <= ST_TWO;
            ST_TWO:   if (m[1]) st_q <= ST_THREE;
            ST_THREE: if (m[2]) st_q <= ST_FOUR;
            ST_FOUR:  st_q <= ST_FOUR;
          endcase
        end
        unique case (st_q)
          ST_ONE: begin
            cnt1_q <= 16'h0000;
            cnt2_q <= 16'h0000;
          end
          ST_TWO: begin
            cnt1_q <= cnt1_q + 16'h0001;
            cnt2_q <= cnt2_q + 16'h0001;
          end
          ST_THREE: cnt2_q <= cnt2_q + 16'h0001;
          ST_FOUR:  cnt2_q <= cnt2_q;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // acquisition memory
  // ----------------------------------------------------------------
  always_ff @(posedge pclk) begin
    if (act && !supp) begin
      mem[wptr_q] <= {sample_addr[15:0], sample_data};
    end
  end
  assign rword = mem[bus.mem_raddr[9:2]];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q <= 8'h00;
    end else begin
      rd_q <= rword[{bus.mem_raddr[1:0], 3'b000} +: 8];
    end
  end

  // ----------------------------------------------------------------
  // slow clock detector and power-on key window
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q  <= 12'h000;
      win_q  <= 32'h0000_0000;
      diag_q <= 1'b0;
    end else begin
      if (sample_valid) begin
        gap_q <= 12'h000;
      end else if (gap_q != 12'hFFF) begin
        gap_q <= gap_q + 12'h001;
      end
      if (win_q < KEY_WIN_CYC) begin
        win_q <= win_q + 32'h0000_0001;
        if (key_held) begin
          diag_q <= 1'b1;
        end
      end
    end
  end

  assign bus.slow_clk   = (gap_q >= 12'(ats_pkg::SLOW_CYC));
  assign bus.store_mode = store_q;
  assign bus.mem_rdata  = rd_q;
  assign bus.cnt1       = cnt1_q;
  assign bus.cnt2       = cnt2_q;
  assign diag_req       = diag_q;
  assign trig_main      = hitp_q;
  assign trig_timing    = hitp_q;
endmodule

// ---- core/ats_seq.sv ----
// Purpose: self-test sequencer: ROM check, recognizer setup, trigger tests
// Assumes: rom_data is valid one cycle after rom_addr; APB slave, no wait
// Notes:   results are read from the status register
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module ats_seq #(
  parameter int unsigned MS_CYC = ats_pkg::MS_CYC
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // module ROM
  output logic [15:0]      rom_addr,
  input  wire logic [7:0]  rom_data,
  // analyzer link
  ats_if.seq               bus
);
  typedef enum logic [4:0] {
    S_IDLE, S_LEN, S_TLO, S_THI, S_SUM, S_SLO, S_SHI, S_REC, S_WAITB,
    S_DISP, S_SLOW, S_STORE, S_WAIT, S_CHK, S_ASUM, S_ALO, S_AHI
  } ats_state_t;

  ats_state_t  st_q, st_d;
  logic        ph_q, busy_q, busy_d, done_q, done_d, pass_q, pass_d, exp_q, exp_d;
  logic [2:0]  test_q, test_d;
  logic [7:0]  yy_q, yy_d, b_q, b_d, wms_q, wms_d, msn_q, msn_d;
  logic [15:0] sum_q, sum_d, ptr_q, ptr_d;
  logic [19:0] code_q, code_d;
  logic [3:0]  fbit_q, fbit_d;
  logic [31:0] wcnt_q, wcnt_d, prdata_q;
  logic [7:0]  rv_q [4];
  logic [7:0]  rv_d [4];

  function automatic logic [3:0] low_bit(input logic [15:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) r = 4'(i);
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire [7:0]  aoff    = paddr[7:0];
  wire        hit_ctl = (aoff == ats_pkg::A_CTRL);
  wire        hit_st  = (aoff == ats_pkg::A_STAT);
  wire        hit_cnt = (aoff == ats_pkg::A_CNT);
  wire        mapped  = (paddr[31:8] == 24'h00_0000) && (hit_ctl || hit_st || hit_cnt);
  wire        wr_ctl  = psel && penable && pwrite && mapped && hit_ctl;
  wire        start   = wr_ctl && pwdata[ats_pkg::CTRL_START] && !busy_q;
  wire [31:0] ctl_rd  = {23'h00_0000, exp_q, 1'b0, test_q, 4'h0};
  wire [31:0] st_rd   = {code_q, fbit_q, 5'h00, pass_q, done_q, busy_q};
  wire [31:0] cnt_rd  = {bus.cnt2, bus.cnt1};
  wire [31:0] rd_mux  = hit_ctl ? ctl_rd : hit_st ? st_rd : hit_cnt ? cnt_rd : 32'h0000_0000;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = prdata_q;

  // ----------------------------------------------------------------
  // link outputs
  // ----------------------------------------------------------------
  wire seq = (test_q == ats_pkg::TEST_SEQ);
  for (genvar gi = 0; gi < 4; gi++) begin : g_rec
    assign bus.rec_val[gi]  = {5{rv_q[gi]}};
    assign bus.rec_care[gi] = exp_q ? '1 : 40'h00FF_FF00FF;
  end
  assign bus.ext_care    = 1'b0;
  assign bus.qual_care   = 10'h000;
  assign bus.shift_div   = 1'b0;
  assign bus.sm_seq      = seq;
  assign bus.delay       = seq ? ats_pkg::SEQ_DELAY : 8'h00;
  assign bus.preset      = seq ? ats_pkg::SEQ_PRESET : 8'h00;
  assign bus.cmd_display = (st_q == S_DISP);
  assign bus.cmd_store   = (st_q == S_STORE);
  assign bus.mem_raddr   = ptr_q[9:0];

  // ----------------------------------------------------------------
  // rom address select
  // ----------------------------------------------------------------
  assign rom_addr = (st_q == S_LEN)   ? ats_pkg::ROM_LEN :
                    (st_q == S_TLO)   ? {yy_q, ats_pkg::TRL_LO} :
                    (st_q == S_THI)   ? {yy_q, ats_pkg::TRL_HI} :
                    (st_q == S_SLO)   ? {yy_q, ats_pkg::SUM_LO} :
                    (st_q == S_SHI)   ? {yy_q, ats_pkg::SUM_HI} :
                    (st_q == S_REC)   ? ats_pkg::ROM_REC + ptr_q :
                    (st_q == S_WAITB) ? ats_pkg::ROM_WAIT :
                    (st_q == S_ALO)   ? ats_pkg::ROM_ACQ_SUM :
                    (st_q == S_AHI)   ? ats_pkg::ROM_ACQ_SUM + 16'h0001 : ptr_q;

  // every read state waits one cycle for its byte, then consumes it
  wire rd_st = (st_q == S_LEN) || (st_q == S_TLO) || (st_q == S_THI) || (st_q == S_SUM) ||
               (st_q == S_SLO) || (st_q == S_SHI) || (st_q == S_REC) ||
               (st_q == S_WAITB) || (st_q == S_ASUM) || (st_q == S_ALO) || (st_q == S_AHI);
  wire rd    = rd_st && ph_q;
  wire [7:0] trl_x = b_q ^ ~rom_data;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q; busy_d = busy_q; done_d = done_q; pass_d = pass_q; exp_d = exp_q;
    test_d = test_q; yy_d = yy_q; b_d = b_q; wms_d = wms_q; msn_d = msn_q;
    sum_d = sum_q; ptr_d = ptr_q; code_d = code_q; fbit_d = fbit_q; wcnt_d = wcnt_q;
    rv_d = rv_q;
    unique case (st_q)
      S_IDLE: if (start) begin
        test_d = pwdata[ats_pkg::CTRL_TEST +: 3];
        exp_d  = pwdata[ats_pkg::CTRL_EXP];
        busy_d = 1'b1; done_d = 1'b0; pass_d = 1'b0;
        code_d = 20'h0_0000; fbit_d = 4'h0; ptr_d = 16'h0000;
        if (pwdata[ats_pkg::CTRL_TEST +: 3] == ats_pkg::TEST_ROM) begin
          st_d = S_LEN;
        end else if (pwdata[ats_pkg::CTRL_TEST +: 3] == ats_pkg::TEST_SINGLE ||
                     pwdata[ats_pkg::CTRL_TEST +: 3] == ats_pkg::TEST_SEQ) begin
          st_d = S_REC;
        end else begin
          busy_d = 1'b0; done_d = 1'b1;
        end
      end
      S_LEN: if (rd) begin yy_d = rom_data; st_d = S_TLO; end
      S_TLO: if (rd) begin b_d = rom_data; st_d = S_THI; end
      S_THI: if (rd) begin
        if (trl_x != 8'h00) begin
          code_d = {ats_pkg::FC_TRL_HI, yy_q, ats_pkg::TRL_HI};
          fbit_d = low_bit({8'h00, trl_x});
          st_d = S_IDLE; busy_d = 1'b0; done_d = 1'b1;
        end else begin
          ptr_d = ats_pkg::ROM_BASE; sum_d = 16'h0000; st_d = S_SUM;
        end
      end
      S_SUM: if (rd) begin
        sum_d = sum_q + {8'h00, rom_data};
        if (ptr_q == {yy_q, ats_pkg::TRL_HI}) st_d = S_SLO;
        else ptr_d = ptr_q + 16'h0001;
      end
      S_SLO: if (rd) begin b_d = rom_data; st_d = S_SHI; end
      S_SHI: if (rd) begin
        st_d = S_IDLE; busy_d = 1'b0; done_d = 1'b1;
        if ({rom_data, b_q} != sum_q) code_d = {4'h0, sum_q};
        else pass_d = 1'b1;
      end
      S_REC: if (rd) begin
        rv_d[ptr_q[1:0]] = rom_data;
        ptr_d = ptr_q + 16'h0001;
        if (ptr_q[1:0] == 2'd3) begin
          wms_d = ats_pkg::SEQ_WAIT_MS;
          st_d  = seq ? S_DISP : S_WAITB;
        end
      end
      S_WAITB: if (rd) begin wms_d = rom_data; st_d = S_DISP; end
      S_DISP: st_d = S_SLOW;
      S_SLOW: if (bus.slow_clk) begin
        code_d = ats_pkg::FC_SLOW; fbit_d = ats_pkg::FB_SLOW;
        st_d = S_IDLE; busy_d = 1'b0; done_d = 1'b1;
      end else st_d = S_STORE;
      S_STORE: begin wcnt_d = 32'h0000_0000; msn_d = 8'h00; st_d = S_WAIT; end
      S_WAIT: begin
        if (msn_q == wms_q) st_d = S_CHK;
        else if (wcnt_q == MS_CYC - 1) begin
          wcnt_d = 32'h0000_0000; msn_d = msn_q + 8'h01;
        end else wcnt_d = wcnt_q + 32'h0000_0001;
      end
      S_CHK: if (bus.store_mode) begin
        code_d = ats_pkg::FC_TRIG; fbit_d = ats_pkg::FB_TRIG;
        st_d = S_IDLE; busy_d = 1'b0; done_d = 1'b1;
      end else if (seq) begin
        ptr_d = 16'h0000; sum_d = 16'h0000; st_d = S_ASUM;
      end else begin
        st_d = S_IDLE; busy_d = 1'b0; done_d = 1'b1; pass_d = 1'b1;
      end
      S_ASUM: if (rd) begin
        sum_d = sum_q + {8'h00, bus.mem_rdata};
        if (ptr_q[9:0] == ats_pkg::ACQ_LAST) st_d = S_ALO;
        else ptr_d = ptr_q + 16'h0001;
      end
      S_ALO: if (rd) begin b_d = rom_data; st_d = S_AHI; end
      S_AHI: if (rd) begin
        st_d = S_IDLE; busy_d = 1'b0; done_d = 1'b1;
        if ({rom_data, b_q} != sum_q) begin
          code_d = ats_pkg::FC_ACQ_SUM;
          fbit_d = low_bit({rom_data, b_q} ^ sum_q);
        end else pass_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= S_IDLE; ph_q <= 1'b0; busy_q <= 1'b0; done_q <= 1'b0; pass_q <= 1'b0;
      exp_q <= ats_pkg::CTRL_RST[ats_pkg::CTRL_EXP];
      test_q <= ats_pkg::CTRL_RST[ats_pkg::CTRL_TEST +: 3];
      yy_q <= 8'h00; b_q <= 8'h00; wms_q <= 8'h00; msn_q <= 8'h00;
      sum_q <= 16'h0000; ptr_q <= 16'h0000; code_q <= 20'h0_0000; fbit_q <= 4'h0;
      wcnt_q <= 32'h0000_0000; prdata_q <= 32'h0000_0000;
      for (int i = 0; i < 4; i++) rv_q[i] <= 8'h00;
    end else begin
      st_q <= st_d; ph_q <= rd_st && !ph_q && (st_d == st_q);
      busy_q <= busy_d; done_q <= done_d; pass_q <= pass_d; exp_q <= exp_d;
      test_q <= test_d; yy_q <= yy_d; b_q <= b_d; wms_q <= wms_d; msn_q <= msn_d;
      sum_q <= sum_d; ptr_q <= ptr_d; code_q <= code_d; fbit_q <= fbit_d;
      wcnt_q <= wcnt_d; rv_q <= rv_d;
      if (psel && !penable && !pwrite) prdata_q <= rd_mux;
    end
  end
endmodule

// ---- sim/ats_trig_asserts.sv ----
// Purpose: link assertions for the self-test pair
// Assumes: one pclk domain
// Notes:   sees the link signals only
`timescale 1ns/1ps
module ats_trig_asserts (
  // clock and reset
  input wire logic                     pclk,
  input wire logic                     presetn,
  // link
  input wire ats_pkg::ats_word_t [3:0] rec_val,
  input wire logic                     ext_care,
  input wire logic                     sm_seq,
  input wire logic [7:0]               delay,
  input wire logic [7:0]               preset,
  input wire logic                     cmd_display,
  input wire logic                     cmd_store,
  input wire logic                     store_mode,
  input wire logic [15:0]              cnt1,
  input wire logic [15:0]              cnt2
);
  // ------------------------------------------
  // link rules
  // ------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ext_dc; ext_care == 1'b0; endproperty
  a_ext_dc: assert property (p_ext_dc) else $error("ext care set");
  property p_store_on; cmd_store |=> store_mode; endproperty
  a_store_on: assert property (p_store_on) else $error("store not entered");
  property p_disp_off; cmd_display |=> !store_mode; endproperty
  a_disp_off: assert property (p_disp_off) else $error("display kept store");
  property p_seq_setup;
    cmd_store && sm_seq |-> delay == ats_pkg::SEQ_DELAY && preset == ats_pkg::SEQ_PRESET;
  endproperty
  a_seq_setup: assert property (p_seq_setup) else $error("bad sequence setup");
  property p_one_delay; cmd_store && !sm_seq |-> delay == 8'h00; endproperty
  a_one_delay: assert property (p_one_delay) else $error("single delay not zero");
  property p_rec_pat;
    cmd_store |-> rec_val[0] == '0 && rec_val[2] == {5{8'hAA}} && rec_val[3] == '1;
  endproperty
  a_rec_pat: assert property (p_rec_pat) else $error("bad pattern load");
  property p_cnt_order; cnt2 >= cnt1; endproperty
  a_cnt_order: assert property (p_cnt_order) else $error("counter order");
  // cnt1 may only move while storing
  property p_cnt_hold; !store_mode && !$past(store_mode) |-> $stable(cnt1); endproperty
  a_cnt_hold: assert property (p_cnt_hold) else $error("counter moved idle");
endmodule

// ---- sim/ats_tb.sv ----
// Purpose: self-checking bench for the trigger self-test pair
// Assumes: 20 MHz pclk; the bench models the ROM and counter stimulus
// Notes:   key window and millisecond count shortened by parameter
`timescale 1ns/1ps
module ats_tb;
  localparam logic [31:0] PASS = 32'h0000_0006;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        key_held = 1'b0, stim_on = 1'b0, sample_valid = 1'b0, pready, pslverr, err;
  logic        diag_req, trig_main, trig_timing;
  logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, prdata, st;
  logic [23:0] sample_addr = 24'h00_0000;
  logic [15:0] sample_data = 16'h0000, rom_addr, sum = 16'h0000, acq = 16'h0000;
  logic [7:0]  rom_data = 8'h00, c8 = 8'h00, rom [0:65535];
  int          n_mismatch = 0, n_tests = 0, n_trig = 0, cyc = 0;
  ats_if       lnk ();
  ats_seq #(.MS_CYC(1000)) ats_seq_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rom_addr(rom_addr), .rom_data(rom_data), .bus(lnk));
  // qualifier pins held low: any cared qualifier bit would block every sample
  ats_anl #(.KEY_WIN_CYC(50)) ats_anl_i (.pclk(pclk), .presetn(presetn), .bus(lnk),
    .sample_valid(sample_valid), .sample_addr(sample_addr), .sample_data(sample_data),
    .sample_qual(10'h000), .ext_trig(1'b0), .key_held(key_held), .diag_req(diag_req),
    .trig_main(trig_main), .trig_timing(trig_timing));
  ats_trig_asserts ats_trig_asserts_i (.pclk(pclk), .presetn(presetn), .rec_val(lnk.rec_val),
    .ext_care(lnk.ext_care), .sm_seq(lnk.sm_seq), .delay(lnk.delay), .preset(lnk.preset),
    .cmd_display(lnk.cmd_display), .cmd_store(lnk.cmd_store), .store_mode(lnk.store_mode),
    .cnt1(lnk.cnt1), .cnt2(lnk.cnt2));
  initial begin
    forever #25 pclk = ~pclk;
  end
  // ------------------------------------------
  // ROM, counter stimulus, trigger count, timeout
  // ------------------------------------------
  always @(posedge pclk) begin
    rom_data     <= rom[rom_addr];
    sample_valid <= stim_on;
    sample_addr  <= {3{c8}};
    sample_data  <= {2{c8}};
    c8           <= c8 + 8'h01;
    cyc          <= cyc + 1;
    if (trig_main && trig_timing)
      n_trig <= n_trig + 1;
    // about three and a half times the expected run length
    if (cyc == 45000) begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {24'h00_0000, a};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    st      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(input logic [2:0] t);
    apb(1'b1, ats_pkg::A_CTRL, (32'(t) << ats_pkg::CTRL_TEST) | 32'h0000_0001);
    do
      apb(1'b0, ats_pkg::A_STAT, 32'h0000_0000);
    while (st[1] !== 1'b1);
  endtask
  task automatic t_power();
    repeat (60) @(posedge pclk);
    key_held <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("late key", 32'(diag_req), 32'h0000_0000);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    key_held <= 1'b0;
    @(posedge pclk);
    chk("early key", 32'(diag_req), 32'h0000_0001);
    apb(1'b0, ats_pkg::A_CTRL, 32'h0000_0000);
    chk("ctrl reset", st, ats_pkg::CTRL_RST);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk("unmapped", {err, st[30:0]}, 32'h8000_0000);
  endtask
  task automatic t_rom();
    logic [7:0] b;
    run(ats_pkg::TEST_ROM);
    chk("rom pass", st, PASS);
    // bits 2 and 4 broken: only the lowest may be reported
    rom[16'hE1FD] = 8'hB1;
    run(ats_pkg::TEST_ROM);
    chk("trailer", st, {ats_pkg::FC_TRL_HI, 8'hE1, ats_pkg::TRL_HI, 12'h202});
    rom[16'hE1FD] = 8'hA5;
    b = rom[16'hE020];
    rom[16'hE020] = rom[16'hE031];
    rom[16'hE031] = b;
    run(ats_pkg::TEST_ROM);
    chk("swapped", st, PASS);
    rom[16'hE1FE] = rom[16'hE1FE] ^ 8'h01;
    run(ats_pkg::TEST_ROM);
    chk("rom sum", st, {4'h0, sum, 12'h002});
    rom[16'hE1FE] = sum[7:0];
  endtask
  task automatic t_one();
    run(ats_pkg::TEST_SINGLE);
    chk("single", st, PASS);
    chk("triggers", 32'(n_trig), 32'h0000_0001);
    chk("care", {lnk.rec_care[1][39:32], lnk.rec_care[2][15:8], 16'h0000}, 32'h0);
    // a gap in the stimulus is what lets the slow-clock detector fire
    stim_on <= 1'b0;
    repeat (220) @(posedge pclk);
    run(ats_pkg::TEST_SINGLE);
    chk("slow", st, {ats_pkg::FC_SLOW, ats_pkg::FB_SLOW, 8'h02});
    stim_on <= 1'b1;
    repeat (20) @(posedge pclk);
    // unknown test code with expansion present: ends at once, masks widen
    apb(1'b1, ats_pkg::A_CTRL, 32'h0000_0101);
    apb(1'b0, ats_pkg::A_CTRL, 32'h0000_0000);
    chk("ctrl exp", st, 32'h0000_0100);
    chk("exp care", lnk.rec_care[1][39:8], 32'hFFFF_FFFF);
    apb(1'b0, ats_pkg::A_STAT, 32'h0000_0000);
    chk("no test", st, 32'h0000_0002);
  endtask
  task automatic t_seq();
    run(ats_pkg::TEST_SEQ);
    chk("sequence", st, PASS);
    chk("triggers", 32'(n_trig), 32'h0000_0002);
    apb(1'b0, ats_pkg::A_CNT, 32'h0000_0000);
    chk("counts", st, 32'h00AA_0055);
    rom[16'hE012] = rom[16'hE012] ^ 8'h10;
    run(ats_pkg::TEST_SEQ);
    chk("acq sum", st, {ats_pkg::FC_ACQ_SUM, 12'h402});
  endtask
  initial begin
    for (int a = 16'hE000; a < 16'hE200; a++)
      rom[a] = 8'(a) ^ 8'h3C;
    // words are {c,c,c,c}: 16 samples before the last match, 240 after it
    for (int i = 0; i < 256; i++)
      acq = acq + 16'(4 * (i < 16 ? 239 + i : i - 16));
    for (int k = 0; k < 4; k++)
      rom[16'hE014 + k] = 8'(85 * k);
    rom[16'hE010] = 8'hE1;
    rom[16'hE011] = 8'h01;
    {rom[16'hE013], rom[16'hE012]} = acq;
    {rom[16'hE1FD], rom[16'hE1FC]} = 16'hA55A;
    for (int a = 16'hE000; a < 16'hE1FE; a++)
      sum = sum + 16'(rom[a]);
    {rom[16'hE1FF], rom[16'hE1FE]} = sum;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_power();
    stim_on <= 1'b1;
    t_rom();
    t_one();
    t_seq();
    test_done();
  end
endmodule
